// File: core/pix_expander.sv
// Purpose: interrupt expander with vector RAM, external edge interrupts and timer routing
// Assumes: synchronous requests from peripherals and timers; pins asynchronous
// Notes: vector RAM read is combinational; all outputs are flip-flops
`timescale 1ns/1ps
module pix_expander (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire pix_pkg::pix_bus_type bus,
  output logic [pix_pkg::DATA_W-1:0] rdData,
  input wire logic [pix_pkg::NUM_SRC-1:0] periphReq,
  input wire logic timer0Req,
  input wire logic timer1Req,
  input wire logic timer2Req,
  input wire logic extInt1Pin,
  input wire logic extInt2Pin,
  input wire logic nmiOrExtInt13Pin,
  input wire logic protUnlockInsn,
  input wire logic protRelockInsn,
  input wire pix_pkg::pix_ack_type ack,
  output logic [pix_pkg::NUM_GROUPS-1:0] cpuIntLines,
  output logic cpuIntLineThirteenth,
  output logic cpuIntLineFourteenth,
  output logic extNonmaskableInt,
  output logic vecValid,
  output logic [pix_pkg::DATA_W-1:0] vecData,
  output logic [6:0] vecSource
);
  import pix_pkg::*;

  pix_state_type s_r;
  pix_state_type s_nxt;
  logic [DATA_W-1:0] vecRam [NUM_SRC];
  logic [2:0] rise;
  logic [2:0] fall;
  logic [3:0] extEdge;
  logic [NUM_SRC-1:0] setVec;
  logic [NUM_SRC-1:0] clrVec;
  logic [GROUP_SIZE-1:0] grpBits;
  logic [NUM_GROUPS-1:0] grpPend;
  logic vecWe;
  logic [6:0] vecIdx;
  logic [3:0] regGrp;
  logic [3:0] ackGrp;
  logic ackHit;
  logic [6:0] ackIdx;
  logic [DATA_W-1:0] vecWord;

  // ----------------------------------------------------------------
  // Vector RAM
  // ----------------------------------------------------------------
  // Held apart from the state struct: no reset, software must load it
  assign vecIdx = 7'(bus.addr - OFF_VEC_BASE);
  assign vecWe = bus.wr && s_r.unlocked && bus.addr >= OFF_VEC_BASE
    && bus.addr < OFF_VEC_END;
  // Out-of-range index reads unknown; only used where the address is decoded
  assign vecWord = vecRam[vecIdx];

  always_ff @(posedge mclk) begin
    if (ce && vecWe) begin
      vecRam[vecIdx][15:0] <= bus.wdata[15:0];
      if (bus.wide) begin
        vecRam[vecIdx][31:16] <= bus.wdata[31:16];
      end
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // Second stage feeds the edge detector; first stage stays private
    s_nxt.sync1 = {nmiOrExtInt13Pin, extInt2Pin, extInt1Pin};
    s_nxt.sync2 = s_r.sync1;
    s_nxt.prev = s_r.sync2;
    rise = s_r.sync2 & ~s_r.prev;
    fall = ~s_r.sync2 & s_r.prev;
    for (int k = 0; k < 4; k++) begin
      // Slot 3 is the non-maskable interrupt on the shared pin
      extEdge[k] = s_r.extCtl[k][EXT_EN_BIT] && (s_r.extCtl[k][EXT_POL_BIT]
        ? rise[(k == 3) ? 2 : k] : fall[(k == 3) ? 2 : k]);
    end
    for (int k = 0; k < 3; k++) begin
      s_nxt.ts[k] = extEdge[k] ? TS_RESET : s_r.ts[k] + 16'h0001;
    end

    setVec = periphReq;
    setVec[TIMER0_POS] = periphReq[TIMER0_POS] | timer0Req;
    setVec[EXT1_POS] = periphReq[EXT1_POS] | extEdge[0];
    setVec[EXT2_POS] = periphReq[EXT2_POS] | extEdge[1];
    setVec = setVec & USED_MASK;
    clrVec = '0;

    // Vector service: lowest position of the group wins
    ackGrp = ack.group - 4'h1;
    ackHit = 1'b0;
    ackIdx = NO_SOURCE;
    grpBits = '0;
    if (ack.group != 4'h0 && ack.group <= 4'(NUM_GROUPS)) begin
      grpBits = s_r.flags[int'(ackGrp) * GROUP_SIZE +: GROUP_SIZE]
        & s_r.ena[int'(ackGrp) * GROUP_SIZE +: GROUP_SIZE];
    end
    for (int b = GROUP_SIZE - 1; b >= 0; b--) begin
      if (grpBits[b]) begin
        ackHit = 1'b1;
        ackIdx = 7'(int'(ackGrp) * GROUP_SIZE + b);
      end
    end
    s_nxt.vecValid = ack.req;
    if (ack.req) begin
      s_nxt.vecSource = ackHit ? ackIdx : NO_SOURCE;
      s_nxt.vecData = ackHit ? vecRam[ackIdx] : '0;
      if (ackHit) begin
        clrVec[ackIdx] = 1'b1;
      end
    end

    // Register writes
    regGrp = 4'(bus.addr - OFF_ENA_BASE);
    if (bus.wr) begin
      if (bus.addr == OFF_CTRL) begin
        s_nxt.ctrl = bus.wdata[1:0];
      end else if (bus.addr >= OFF_EXT1 && bus.addr <= OFF_NMI) begin
        s_nxt.extCtl[2'(bus.addr - OFF_EXT1)] = bus.wdata[1:0];
      end else if (bus.addr >= OFF_ENA_BASE && bus.addr < OFF_ENA_END) begin
        s_nxt.ena[int'(regGrp) * GROUP_SIZE +: GROUP_SIZE] = bus.wdata[7:0];
      end else if (bus.addr >= OFF_FLAG_BASE && bus.addr < OFF_FLAG_END) begin
        clrVec[int'(4'(bus.addr - OFF_FLAG_BASE)) * GROUP_SIZE +: GROUP_SIZE] =
          bus.wdata[7:0];
      end
    end
    // A request arriving with its clear is kept
    s_nxt.flags = (s_r.flags & ~clrVec) | setVec;

    for (int g = 0; g < NUM_GROUPS; g++) begin
      grpPend[g] = |(s_r.flags[g * GROUP_SIZE +: GROUP_SIZE]
        & s_r.ena[g * GROUP_SIZE +: GROUP_SIZE]);
    end
    s_nxt.lines = s_r.ctrl[CTRL_GLOBAL_EN_BIT] ? grpPend : '0;
    s_nxt.line13 = s_r.ctrl[CTRL_T1_ROUTE_BIT] ? timer1Req : extEdge[2];
    s_nxt.line14 = timer2Req;
    s_nxt.nmi = extEdge[3];

    if (protUnlockInsn) begin
      s_nxt.unlocked = 1'b1;
    end else if (protRelockInsn) begin
      s_nxt.unlocked = 1'b0;
    end

    // Register reads: 16-bit reads see the low half
    s_nxt.rdData = '0;
    if (bus.rd) begin
      if (bus.addr == OFF_CTRL) begin
        s_nxt.rdData[1:0] = s_r.ctrl;
      end else if (bus.addr >= OFF_EXT1 && bus.addr <= OFF_NMI) begin
        s_nxt.rdData[1:0] = s_r.extCtl[2'(bus.addr - OFF_EXT1)];
      end else if (bus.addr >= OFF_TS1 && bus.addr <= OFF_TS13) begin
        s_nxt.rdData[TS_W-1:0] = s_r.ts[2'(bus.addr - OFF_TS1)];
      end else if (bus.addr == OFF_STAT) begin
        s_nxt.rdData[0] = s_r.unlocked;
      end else if (bus.addr >= OFF_ENA_BASE && bus.addr < OFF_ENA_END) begin
        s_nxt.rdData[7:0] = s_r.ena[int'(regGrp) * GROUP_SIZE +: GROUP_SIZE];
      end else if (bus.addr >= OFF_FLAG_BASE && bus.addr < OFF_FLAG_END) begin
        s_nxt.rdData[7:0] =
          s_r.flags[int'(4'(bus.addr - OFF_FLAG_BASE)) * GROUP_SIZE +: GROUP_SIZE];
      end else if (bus.addr >= OFF_VEC_BASE && bus.addr < OFF_VEC_END) begin
        s_nxt.rdData = bus.wide ? vecWord : {16'h0000, vecWord[15:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
      s_r.ctrl <= CTRL_RESET;
      s_r.extCtl <= {4{EXT_CTL_RESET}};
      s_r.ts <= {3{TS_RESET}};
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign rdData = s_r.rdData;
  assign cpuIntLines = s_r.lines;
  assign cpuIntLineThirteenth = s_r.line13;
  assign cpuIntLineFourteenth = s_r.line14;
  assign extNonmaskableInt = s_r.nmi;
  assign vecValid = s_r.vecValid;
  assign vecData = s_r.vecData;
  assign vecSource = s_r.vecSource;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_unused_never_pend: assert property ((s_r.flags & ~USED_MASK) == '0)
    else $error("unwired position pending");
  a_line_follows_pend: assert property (ce |=> cpuIntLines ==
    ($past(s_r.ctrl[CTRL_GLOBAL_EN_BIT]) ? $past(grpPend) : '0))
    else $error("group line does not follow enabled pending");
  a_vector_answer: assert property (ce && ack.req |-> ##[1:8] vecValid)
    else $error("vector not supplied in time");
  // Watches the stored word itself, so a leak around the lock is caught
  a_locked_no_write: assert property (ce && bus.wr && !s_r.unlocked
    && bus.addr >= OFF_VEC_BASE && bus.addr < OFF_VEC_END
    |=> vecRam[$past(vecIdx)] == $past(vecWord))
    else $error("vector write while locked");
  a_relock_blocks: assert property (ce && protRelockInsn && !protUnlockInsn
    |=> !s_r.unlocked)
    else $error("relock did not lock");
  a_ts_edge_clear: assert property (ce && extEdge[0] |=> s_r.ts[0] == TS_RESET)
    else $error("timestamp not cleared on edge");
  a_ts_free_run: assert property (ce && !extEdge[1]
    |=> s_r.ts[1] == $past(s_r.ts[1]) + 16'h0001)
    else $error("timestamp not counting");
  a_timer2_direct: assert property (ce |=> cpuIntLineFourteenth == $past(timer2Req))
    else $error("line fourteen not following timer 2");
  a_nmi_disabled: assert property (!s_r.extCtl[3][EXT_EN_BIT] && ce |=> !extNonmaskableInt)
    else $error("disabled non-maskable interrupt fired");

  c_vector_served: cover property (ce && ack.req ##1 vecValid && vecSource != NO_SOURCE);
  c_ext_edge: cover property (extEdge[0] ##1 s_r.ts[0] == TS_RESET);
  c_group_line: cover property (cpuIntLines[0] ##[1:20] !cpuIntLines[0]);
  c_unlock_write: cover property (vecWe);

endmodule // pix_expander

// File: pkg/pix_pkg.sv
// Purpose: constants and carrier types for the peripheral interrupt expander
// Assumes: one clock, word-indexed register port, 12 groups of 8 request positions
// Notes: register offsets are word indices on the plain register port
//
// Overview of operation
// - Accept up to 96 peripheral request inputs, multiplexed onto fewer processor lines.
// - Requests form groups of 8; each group drives one of 12 processor lines.
// - Only 45 positions are wired; unused positions never raise a request.
// - Each position owns a software-writable vector entry in a RAM block.
// - Vector is supplied automatically on service, within 8 processor clock cycles.
// - Each position has its own enable; disabled positions never reach the line.
// - Service order set by fixed hardware priority plus software enables and masking.
// - Three maskable external interrupt inputs: ext_int_1, ext_int_2, ext_int_13.
// - ext_int_13 and the non-maskable interrupt share the combined pin.
// - Each external interrupt selects falling or rising edge triggering.
// - Each external interrupt, non-maskable included, has an enable; disabled edges ignored.
// - Each maskable external interrupt owns a free-running 16-bit timestamp counter.
// - A valid edge on a maskable external input clears its timestamp counter.
// - Timer 2 interrupt drives processor line fourteen directly.
// - Timer 1 interrupt can be connected to processor line thirteen directly.
// - Timer 0 interrupt enters the expander as a peripheral request input.
// - Control registers accept 16-bit and 32-bit reads and writes.
// - Vector RAM writes ignored until unlock instruction; relock instruction blocks them again.
package pix_pkg;
  localparam int NUM_GROUPS = 12;
  localparam int GROUP_SIZE = 8;
  localparam int NUM_SRC = 96;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int TS_W = 16;
  localparam int VEC_LATENCY_MAX = 8;

  // Register map (word indices)
  localparam logic [9:0] OFF_CTRL = 10'h000;
  localparam logic [9:0] OFF_EXT1 = 10'h004;
  localparam logic [9:0] OFF_EXT2 = 10'h005;
  localparam logic [9:0] OFF_EXT13 = 10'h006;
  localparam logic [9:0] OFF_NMI = 10'h007;
  localparam logic [9:0] OFF_TS1 = 10'h008;
  localparam logic [9:0] OFF_TS2 = 10'h009;
  localparam logic [9:0] OFF_TS13 = 10'h00A;
  localparam logic [9:0] OFF_STAT = 10'h00B;
  localparam logic [9:0] OFF_ENA_BASE = 10'h010;
  localparam logic [9:0] OFF_ENA_END = 10'h01C;
  localparam logic [9:0] OFF_FLAG_BASE = 10'h020;
  localparam logic [9:0] OFF_FLAG_END = 10'h02C;
  localparam logic [9:0] OFF_VEC_BASE = 10'h100;
  localparam logic [9:0] OFF_VEC_END = 10'h160;

  // Field positions and reset values
  localparam int CTRL_GLOBAL_EN_BIT = 0;
  localparam int CTRL_T1_ROUTE_BIT = 1;
  localparam int EXT_EN_BIT = 0;
  localparam int EXT_POL_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [1:0] EXT_CTL_RESET = 2'h0;
  localparam logic [TS_W-1:0] TS_RESET = 16'h0000;

  // Wired positions: bits 0..4 of groups 1..9, 45 in all
  localparam logic [95:0] USED_MASK = {{3{8'h00}}, {9{8'h1F}}};
  localparam int TIMER0_POS = 4;
  localparam int EXT1_POS = 3;
  localparam int EXT2_POS = 2;
  localparam logic [6:0] NO_SOURCE = 7'h7F;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
    logic wide;
  } pix_bus_type;

  typedef struct packed {
    logic req;
    logic [3:0] group;
  } pix_ack_type;

  typedef struct packed {
    logic [NUM_SRC-1:0] flags;
    logic [NUM_SRC-1:0] ena;
    logic [1:0] ctrl;
    logic [3:0][1:0] extCtl;
    logic [2:0][TS_W-1:0] ts;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] prev;
    logic unlocked;
    logic [DATA_W-1:0] rdData;
    logic [NUM_GROUPS-1:0] lines;
    logic line13;
    logic line14;
    logic nmi;
    logic vecValid;
    logic [DATA_W-1:0] vecData;
    logic [6:0] vecSource;
  } pix_state_type;
endpackage

// File: tb/pix_cpu_model.sv
// Purpose: processor side model that answers raised group lines with acknowledges
// Assumes: group lines are levels; one acknowledge in flight at a time
// Notes: holds off after each acknowledge so a line still high is not served twice
`timescale 1ns/1ps
module pix_cpu_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic autoAck,
  input wire logic [pix_pkg::NUM_GROUPS-1:0] cpuIntLines,
  output pix_pkg::pix_ack_type ack
);
  import pix_pkg::*;
  logic [3:0] holdCnt;
  // Fixed priority: the lowest numbered raised line is served first
  function automatic logic [3:0] lowGroup(input logic [NUM_GROUPS-1:0] l);
    lowGroup = 4'h0;
    for (int i = NUM_GROUPS - 1; i >= 0; i--) begin
      if (l[i]) begin
        lowGroup = 4'(i + 1);
      end
    end
  endfunction
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ack <= '0;
      holdCnt <= 4'h0;
    end else begin
      ack.req <= 1'b0;
      if (holdCnt != 4'h0) begin
        holdCnt <= holdCnt - 4'h1;
      end else if (autoAck && (cpuIntLines != '0)) begin
        ack.req <= 1'b1;
        ack.group <= lowGroup(cpuIntLines);
        holdCnt <= 4'h8;
      end
    end
  end
endmodule // pix_cpu_model

// File: tb/pix_expander_tb.sv
// Purpose: register-call tests of the interrupt expander
// Assumes: plain register port, one clock at 200 MHz
// Notes: timestamp values are checked only as small after a clear
`timescale 1ns/1ps
module pix_expander_tb;
  import pix_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic autoAck = 1'b0;
  pix_bus_type bus = '0;
  logic [DATA_W-1:0] rdData;
  logic [NUM_SRC-1:0] periphReq = '0;
  logic timer0Req = 1'b0;
  logic timer1Req = 1'b0;
  logic timer2Req = 1'b0;
  logic pin1 = 1'b0;
  logic pin2 = 1'b0;
  logic pinN = 1'b0;
  logic unlock = 1'b0;
  logic relock = 1'b0;
  logic ce = 1'b1;
  logic rdWide = 1'b1;
  pix_ack_type ack;
  logic [NUM_GROUPS-1:0] cpuIntLines;
  logic cpuIntLineThirteenth;
  logic cpuIntLineFourteenth;
  logic extNonmaskableInt;
  logic vecValid;
  logic [DATA_W-1:0] vecData;
  logic [6:0] vecSource;
  int failures = 0;
  int nTests = 0;
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  pix_expander pix_expander_inst (.mclk(mclk), .reset(reset), .ce(ce), .bus(bus),
    .rdData(rdData), .periphReq(periphReq), .timer0Req(timer0Req), .timer1Req(timer1Req),
    .timer2Req(timer2Req), .extInt1Pin(pin1), .extInt2Pin(pin2), .nmiOrExtInt13Pin(pinN),
    .protUnlockInsn(unlock), .protRelockInsn(relock), .ack(ack), .cpuIntLines(cpuIntLines),
    .cpuIntLineThirteenth(cpuIntLineThirteenth), .cpuIntLineFourteenth(cpuIntLineFourteenth),
    .extNonmaskableInt(extNonmaskableInt), .vecValid(vecValid), .vecData(vecData),
    .vecSource(vecSource));
  pix_cpu_model pix_cpu_model_inst (.mclk(mclk), .reset(reset), .autoAck(autoAck),
    .cpuIntLines(cpuIntLines), .ack(ack));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d failures %0d", nTests, failures);
    if ((failures == 0) && (nTests > 0)) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrReg(input logic [9:0] a, input logic [31:0] d, input logic w);
    @(posedge mclk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wide <= w;
    bus.wr <= 1'b1;
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask
  // Mask lets a free-running count be checked as merely small
  task automatic rdReg(input logic [9:0] a, input logic [31:0] exp, input logic [31:0] m);
    @(posedge mclk);
    bus.addr <= a;
    bus.wide <= rdWide;
    bus.rd <= 1'b1;
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1;
    chk("rdData", exp, rdData & m);
  endtask
  task automatic pulseReq(input logic [NUM_SRC-1:0] v);
    @(posedge mclk);
    periphReq <= v;
    @(posedge mclk);
    periphReq <= '0;
  endtask
  function automatic logic pick(input int sel);
    case (sel)
      0: pick = extNonmaskableInt;
      1: pick = cpuIntLineFourteenth;
      2: pick = cpuIntLineThirteenth;
      default: pick = vecValid;
    endcase
  endfunction
  // Bounded wait; running out ends the run
  task automatic waitFor(input int sel);
    for (int i = 0; i < 16; i++) begin
      @(posedge mclk);
      #1;
      if (pick(sel) === 1'b1) begin
        nTests++;
        return;
      end
    end
    failures++;
    $display("ERROR wait %0d expected 1 seen 0", sel);
    stop_test();
  endtask
  task automatic expSrc(input logic [6:0] s);
    waitFor(3);
    chk("vecSource", {25'h0, s}, {25'h0, vecSource});
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    rdReg(OFF_CTRL, 32'h0, 32'hFFFFFFFF);
    rdReg(OFF_STAT, 32'h0, 32'hFFFFFFFF);
    @(posedge mclk);
    unlock <= 1'b1;
    @(posedge mclk);
    unlock <= 1'b0;
    rdReg(OFF_STAT, 32'h1, 32'hFFFFFFFF);
    wrReg(OFF_VEC_BASE, 32'h12345678, 1'b1);
    wrReg(OFF_VEC_BASE + 10'h1, 32'hAAAA5555, 1'b1);
    wrReg(OFF_VEC_BASE + 10'h1, 32'h0000BEEF, 1'b0);
    rdReg(OFF_VEC_BASE + 10'h1, 32'hAAAABEEF, 32'hFFFFFFFF);
    // Narrow read must show only the low half
    rdWide = 1'b0;
    rdReg(OFF_VEC_BASE + 10'h1, 32'h0000BEEF, 32'hFFFFFFFF);
    rdWide = 1'b1;
    @(posedge mclk);
    relock <= 1'b1;
    @(posedge mclk);
    relock <= 1'b0;
    wrReg(OFF_VEC_BASE, 32'h0, 1'b1);
    rdReg(OFF_VEC_BASE, 32'h12345678, 32'hFFFFFFFF);
    rdReg(10'h3FF, 32'h0, 32'hFFFFFFFF);
    // Position 1 of group one stays disabled; group ten has no sources
    wrReg(OFF_ENA_BASE, 32'h1D, 1'b1);
    wrReg(OFF_ENA_BASE + 10'h1, 32'hFF, 1'b1);
    wrReg(OFF_ENA_BASE + 10'h9, 32'hFF, 1'b1);
    wrReg(OFF_CTRL, 32'h1, 1'b1);
    pulseReq(96'h2);
    pulseReq({24'h000001, 72'h0} | 96'h2000);
    // Clock enable low: a request pulse must leave no flag behind
    ce <= 1'b0;
    pulseReq(96'h1);
    ce <= 1'b1;
    rdReg(OFF_FLAG_BASE, 32'h02, 32'hFFFFFFFF);
    repeat (4) @(posedge mclk);
    #1;
    chk("cpuIntLines", 32'h0, {20'h0, cpuIntLines});
    autoAck <= 1'b1;
    pulseReq(96'h109);
    expSrc(7'h00);
    chk("vecData", 32'h12345678, vecData);
    expSrc(7'h03);
    expSrc(7'h08);
    repeat (4) @(posedge mclk);
    #1;
    chk("cpuIntLines", 32'h0, {20'h0, cpuIntLines});
    @(posedge mclk);
    timer0Req <= 1'b1;
    @(posedge mclk);
    timer0Req <= 1'b0;
    expSrc(7'h04);
    @(posedge mclk);
    timer2Req <= 1'b1;
    waitFor(1);
    @(posedge mclk);
    timer2Req <= 1'b0;
    wrReg(OFF_CTRL, 32'h3, 1'b1);
    timer1Req <= 1'b1;
    waitFor(2);
    @(posedge mclk);
    timer1Req <= 1'b0;
    wrReg(OFF_CTRL, 32'h1, 1'b1);
    autoAck <= 1'b0;
    wrReg(OFF_EXT1, 32'h3, 1'b1);
    pin1 <= 1'b1;
    repeat (6) @(posedge mclk);
    rdReg(OFF_FLAG_BASE, 32'h0A, 32'hFFFFFFFF);
    rdReg(OFF_TS1, 32'h0, 32'hFFF0);
    wrReg(OFF_FLAG_BASE, 32'h08, 1'b1);
    repeat (6) @(posedge mclk);
    rdReg(OFF_FLAG_BASE, 32'h02, 32'hFFFFFFFF);
    @(posedge mclk);
    pin2 <= 1'b1;
    repeat (6) @(posedge mclk);
    rdReg(OFF_FLAG_BASE, 32'h02, 32'hFFFFFFFF);
    wrReg(OFF_NMI, 32'h1, 1'b1);
    pinN <= 1'b1;
    repeat (6) @(posedge mclk);
    pinN <= 1'b0;
    waitFor(0);
    stop_test();
  end
endmodule // pix_expander_tb
